// file: logic/flash_program_erase_guard.sv
/*
  program-flash guard: unlock keys, store enables, page locking, byte program,
  page and device erase, flash-error reset and read one-shot setting.
  assumes core and debug port run on clk_in and give one-cycle request pulses.
*/
// Contract
// R01: software writes first key, then second key
// R02: wrong key order or value blocks until reset
// R03: flash op before unlock blocks until reset
// R04: relock after every completed write or erase
// R05: write enable steers data writes to flash
// R06: byte write only clears bits
// R07: enabled erase sets whole page to erased
// R08: hardware times operations and stalls core
// R09: write needs write enable; erase needs both
// R10: lock n pages from zero, n complement
// R11: lock page locked when lock byte not ones
// R12: debug accesses unlocked pages, refuses locked
// R13: lock byte read always allowed
// R14: only debug device erase clears lock byte
// R15: unlocked firmware: no locked pages, no lockpage erase
// R16: locked firmware: all but lock page erase
// R17: firmware never sets lock byte bits back
// R18: reserved or forbidden access causes error reset
// R19: one-shot enable resets set, selects sense mode
// R20: access above user limit causes error reset
// R21: error reset sets the flash error flag
// R22: program stores old byte AND new byte
`timescale 1ns/1ps
`default_nettype none

module flash_program_erase_guard #(
  parameter int ERASE_COUNT = flash_guard_pkg::ERASE_CYCLES
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic other_reset_in,
  // register port
  input wire logic [7:0] sfr_addr_in,
  input wire logic sfr_wr_in,
  input wire logic sfr_rd_in,
  input wire logic [7:0] sfr_wdata_in,
  output logic [7:0] sfr_rdata_out,
  // core data writes, code reads, fetches
  input wire logic xwr_in,
  input wire logic [15:0] xaddr_in,
  input wire logic [7:0] xdata_in,
  input wire logic cread_in,
  input wire logic [15:0] caddr_in,
  input wire logic fetch_in,
  input wire logic [15:0] fetch_addr_in,
  output logic [7:0] cread_data_out,
  output logic cread_valid_out,
  output logic xram_wr_out,
  output logic stall_out,
  // debug port
  input wire logic dbg_rd_in,
  input wire logic dbg_wr_in,
  input wire logic dbg_page_erase_in,
  input wire logic dbg_device_erase_in,
  input wire logic [15:0] dbg_addr_in,
  input wire logic [7:0] dbg_wdata_in,
  output logic [7:0] dbg_rdata_out,
  output logic dbg_done_out,
  output logic dbg_refused_out,
  // system and array side
  output logic flash_error_reset_out,
  output logic sense_oneshot_out,
  output logic sense_enable_out
);
  import flash_guard_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // state
  unlock_t lk_q, lk_d; // key sequence
  engine_t st_q, st_d; // operation engine
  logic [12:0] addr_q, addr_d; // current array address
  logic [12:0] end_q, end_d; // last erase address
  logic [7:0] data_q, data_d; // program data
  logic [CNT_W-1:0] cnt_q, cnt_d; // hold timer
  logic [1:0] kind_q, kind_d; // [1] program, [0] from debug
  logic [7:0] lock_q, lock_d; // lock byte copy
  logic wen_q, een_q; // store enables
  logic [7:0] timing_q; // read timing register
  logic ferr_q; // flash error flag
  logic exec_locked_q; // code runs from a locked page
  logic [7:0] mem_rdata, mem_wdata;
  logic mem_we;

  // firmware access check, shared by data writes and code reads
  function automatic logic fw_ok(input logic [15:0] a, input logic erase, input logic rd,
                                 input logic [7:0] lockb, input logic exec_lk);
    logic [3:0] pg;
    pg = page_of(a);
    if (a > USER_LIMIT) fw_ok = 1'b0; // R18
    else if (rd && a[12:0] == LOCK_ADDR) fw_ok = 1'b1; // R13
    else if (pg == LOCK_PAGE) fw_ok = !erase && (exec_lk || lockb == ERASED); // R15 R16 R17
    else if (page_locked(pg, lockb)) fw_ok = exec_lk; // R15 R16
    else fw_ok = 1'b1;
  endfunction

  // debug access check
  function automatic logic dbg_ok(input logic [15:0] a, input logic rd,
                                  input logic [7:0] lockb);
    dbg_ok = (a <= USER_LIMIT) &&
             (!page_locked(page_of(a), lockb) || (rd && a[12:0] == LOCK_ADDR)); // R12 R13
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // request decode
  wire idle = (st_q == E_IDLE);
  wire key_wr = sfr_wr_in && (sfr_addr_in == KEY_REG_ADDR);
  wire ctrl_wr = sfr_wr_in && (sfr_addr_in == CTRL_REG_ADDR);
  wire timing_wr = sfr_wr_in && (sfr_addr_in == TIMING_REG_ADDR);
  wire fw_wr = idle && xwr_in && wen_q; // R05 R09
  wire ram_wr = idle && xwr_in && !wen_q; // R05
  wire fw_bad_wr = fw_wr && !fw_ok(xaddr_in, een_q, 1'b0, lock_q, exec_locked_q); // R18
  wire code_bad = idle && cread_in && !fw_ok(caddr_in, 1'b0, 1'b1, lock_q, exec_locked_q); // R20
  wire fetch_bad = idle && fetch_in && (fetch_addr_in > USER_LIMIT); // R20
  wire fw_err = fw_bad_wr || code_bad || fetch_bad;
  wire fw_start = fw_wr && !fw_err && (lk_q == LK_OPEN); // R01 R09
  wire fw_blocked = fw_wr && !fw_err && (lk_q != LK_OPEN); // R03
  wire code_go = idle && cread_in && !fw_err && !fw_wr;
  wire dbg_any = idle && !fw_err && !fw_wr && !cread_in;
  wire sel_de = dbg_any && dbg_device_erase_in;
  wire sel_pe = dbg_any && !dbg_device_erase_in && dbg_page_erase_in;
  wire sel_wr = dbg_any && !dbg_device_erase_in && !dbg_page_erase_in && dbg_wr_in;
  wire sel_rd = dbg_any && !dbg_device_erase_in && !dbg_page_erase_in && !dbg_wr_in &&
                dbg_rd_in;
  wire ok_w = dbg_ok(dbg_addr_in, 1'b0, lock_q);
  wire ok_r = dbg_ok(dbg_addr_in, 1'b1, lock_q);
  wire refuse = ((sel_pe || sel_wr) && !ok_w) || (sel_rd && !ok_r); // R12
  wire [3:0] xpage = page_of(xaddr_in);
  wire [3:0] dpage = page_of(dbg_addr_in);
  wire hold_end = (st_q == E_HOLD) && (cnt_q == CNT_W'(1));

  // array port: program merges old and new, erase writes the erased value
  assign mem_we = ((st_q == E_MERGE) && kind_q[1]) || (st_q == E_ERASE);
  assign mem_wdata = (st_q == E_ERASE) ? ERASED : (mem_rdata & data_q); // R06 R22 R07

  ////////////////////////////////////////////////////////////////////////////
  // unlock sequence next state
  always_comb begin
    lk_d = lk_q;
    if (fw_err) begin
      lk_d = LK_IDLE; // error reset restarts the sequence
    end else if (key_wr) begin
      case (lk_q)
        LK_IDLE: lk_d = (sfr_wdata_in == KEY_FIRST) ? LK_HALF : LK_DEAD; // R01 R02
        LK_HALF: lk_d = (sfr_wdata_in == KEY_SECOND) ? LK_OPEN : LK_DEAD; // R01 R02
        default: lk_d = LK_DEAD; // R02
      endcase
    end else if (fw_start) begin
      lk_d = LK_IDLE; // R04
    end else if (fw_blocked) begin
      lk_d = LK_DEAD; // R03
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // operation engine next state
  always_comb begin
    st_d = st_q;
    addr_d = addr_q;
    end_d = end_q;
    data_d = data_q;
    cnt_d = cnt_q;
    kind_d = kind_q;
    lock_d = lock_q;
    case (st_q)
      E_BOOT: st_d = E_BOOTLD; // read lock byte after reset
      E_BOOTLD: begin
        lock_d = mem_rdata; // R10 R11
        st_d = E_IDLE;
      end
      E_IDLE: begin
        if (fw_start && een_q) begin
          addr_d = {xpage, PAGE_OFF_FIRST}; // R07
          end_d = {xpage, PAGE_OFF_LAST};
          kind_d = 2'b00;
          st_d = E_ERASE;
        end else if (fw_start) begin
          addr_d = xaddr_in[12:0];
          data_d = xdata_in;
          kind_d = 2'b10;
          st_d = E_READ;
        end else if (code_go) begin
          addr_d = caddr_in[12:0];
          kind_d = 2'b00;
          st_d = E_READ;
        end else if (sel_de) begin
          addr_d = 13'h0000; // R14
          end_d = LOCK_ADDR;
          kind_d = 2'b01;
          st_d = E_ERASE;
        end else if (sel_pe && ok_w) begin
          addr_d = {dpage, PAGE_OFF_FIRST};
          end_d = {dpage, PAGE_OFF_LAST};
          kind_d = 2'b01;
          st_d = E_ERASE;
        end else if ((sel_wr && ok_w) || (sel_rd && ok_r)) begin
          addr_d = dbg_addr_in[12:0];
          data_d = dbg_wdata_in;
          kind_d = {sel_wr, 1'b1};
          st_d = E_READ;
        end
      end
      E_READ: st_d = E_MERGE;
      E_MERGE: begin
        if (kind_q[1]) begin
          if (addr_q == LOCK_ADDR) begin
            lock_d = lock_q & data_q; // R17
          end
          cnt_d = CNT_W'(WRITE_CYCLES); // R08
          st_d = E_HOLD;
        end else begin
          st_d = E_IDLE;
        end
      end
      E_ERASE: begin
        if (addr_q == LOCK_ADDR) begin
          lock_d = ERASED; // R14
        end
        if (addr_q == end_q) begin
          cnt_d = CNT_W'(ERASE_COUNT); // R08
          st_d = E_HOLD;
        end else begin
          addr_d = addr_q + 13'h0001;
        end
      end
      E_HOLD: begin
        if (cnt_q == CNT_W'(1)) st_d = E_IDLE;
        else cnt_d = cnt_q - CNT_W'(1);
      end
      default: st_d = E_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // flash array
  flash_byte_array u_array (
    .clk_in(clk_in),
    .addr_in(addr_q),
    .we_in(mem_we),
    .wdata_in(mem_wdata),
    .rdata_out(mem_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // engine and sequence registers
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      lk_q <= LK_IDLE;
      st_q <= E_BOOT;
      addr_q <= LOCK_ADDR;
      end_q <= 13'h0000;
      data_q <= 8'h00;
      cnt_q <= '0;
      kind_q <= 2'b00;
      lock_q <= ERASED;
    end else begin
      lk_q <= lk_d;
      st_q <= st_d;
      addr_q <= addr_d;
      end_q <= end_d;
      data_q <= data_d;
      cnt_q <= cnt_d;
      kind_q <= kind_d;
      lock_q <= lock_d;
    end
  end

  // software registers; an error reset returns the store enables and timing register to reset values and sets the error flag
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wen_q <= 1'b0;
      een_q <= 1'b0;
      timing_q <= TIMING_RESET; // R19
      ferr_q <= 1'b0;
      exec_locked_q <= 1'b0;
    end else begin
      wen_q <= fw_err ? 1'b0 : (ctrl_wr ? sfr_wdata_in[WEN_BIT] : wen_q); // R05
      een_q <= fw_err ? 1'b0 : (ctrl_wr ? sfr_wdata_in[EEN_BIT] : een_q); // R09
      timing_q <= fw_err ? TIMING_RESET : (timing_wr ? (sfr_wdata_in & TIMING_MASK) : timing_q);
      ferr_q <= fw_err || (ferr_q && !other_reset_in); // R21
      if (fetch_in && !fetch_bad) begin
        exec_locked_q <= page_locked(page_of(fetch_addr_in), lock_q); // R16
      end
    end
  end

  // register read data
  wire [7:0] rd_mux = (sfr_addr_in == TIMING_REG_ADDR) ? timing_q :
                      (sfr_addr_in == CTRL_REG_ADDR) ? {6'h00, een_q, wen_q} :
                      (sfr_addr_in == KEY_REG_ADDR) ? {6'h00, lk_q} :
                      (sfr_addr_in == RESET_SOURCE_REGISTER_REG_ADDR) ? {1'b0, ferr_q, 6'h00} : 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // registered outputs
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      sfr_rdata_out <= 8'h00;
      cread_data_out <= 8'h00;
      cread_valid_out <= 1'b0;
      dbg_rdata_out <= 8'h00;
      dbg_done_out <= 1'b0;
      dbg_refused_out <= 1'b0;
      xram_wr_out <= 1'b0;
      stall_out <= 1'b1;
      flash_error_reset_out <= 1'b0;
      sense_oneshot_out <= 1'b1;
      sense_enable_out <= 1'b0;
    end else begin
      if (sfr_rd_in) sfr_rdata_out <= rd_mux;
      if ((st_q == E_MERGE) && (kind_q == 2'b00)) cread_data_out <= mem_rdata;
      cread_valid_out <= (st_q == E_MERGE) && (kind_q == 2'b00);
      if ((st_q == E_MERGE) && (kind_q == 2'b01)) dbg_rdata_out <= mem_rdata;
      dbg_done_out <= ((st_q == E_MERGE) && (kind_q == 2'b01)) || (hold_end && kind_q[0]);
      dbg_refused_out <= refuse; // R12
      xram_wr_out <= ram_wr; // R05
      stall_out <= (st_d != E_IDLE); // R08
      flash_error_reset_out <= fw_err; // R18 R20
      sense_oneshot_out <= timing_q[ONESHOT_BIT]; // R19
      sense_enable_out <= (st_d == E_READ) || (st_d == E_BOOT); // R19
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  a_key_wrong_first: assert property ((key_wr && lk_q == LK_IDLE && !fw_err &&
    sfr_wdata_in != KEY_FIRST) |=> (lk_q == LK_DEAD)[*3]) else $error("bad key not latched"); // R02
  a_early_op_dead: assert property (fw_blocked |=> lk_q == LK_DEAD && stall_out == 1'b0)
    else $error("early flash op not blocking"); // R03
  a_relock_after: assert property (fw_start |=> lk_q == LK_IDLE && stall_out)
    else $error("no relock after op"); // R04
  a_ram_diverted: assert property (xwr_in && idle |=> xram_wr_out == !$past(wen_q))
    else $error("data write routed wrongly"); // R05
  a_program_and: assert property ((st_q == E_MERGE && kind_q[1]) |-> mem_we &&
    mem_wdata == (mem_rdata & data_q)) else $error("program not bitwise and"); // R06
  a_erase_value: assert property (st_q == E_ERASE |-> mem_we && mem_wdata == ERASED)
    else $error("erase value wrong"); // R07
  a_write_stalls: assert property ((st_q == E_MERGE && kind_q[1]) |=> stall_out[*8])
    else $error("stall dropped during write"); // R08
  a_fetch_limit: assert property (fetch_bad |=> flash_error_reset_out && ferr_q)
    else $error("fetch above limit not reset"); // R20
  a_lockpage_erase: assert property ((fw_wr && een_q && xpage == LOCK_PAGE) |=>
    flash_error_reset_out) else $error("lock page erase allowed"); // R15
  a_dbg_refused: assert property ((sel_rd && !ok_r) |=> dbg_refused_out && !stall_out)
    else $error("locked debug read not refused"); // R12

  c_page_erase: cover property (st_q == E_ERASE && kind_q == 2'b00 ##1 st_q == E_ERASE);
  c_byte_prog: cover property (st_q == E_MERGE && kind_q == 2'b10);
  c_flash_error: cover property (flash_error_reset_out);
  c_dbg_dev_erase: cover property (sel_de);

endmodule

`default_nettype wire

// file: common/flash_guard_pkg.sv
/*
  constants, encodings and helper functions shared by the program-flash guard.
  assumes a byte-wide register port, a 13-bit flash byte address and one 50 MHz clock.
*/
package flash_guard_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register offsets on the byte register port
  localparam logic [7:0] TIMING_REG_ADDR = 8'hb6; // flash_read_timing_control
  localparam logic [7:0] KEY_REG_ADDR = 8'hb7; // unlock_key_register
  localparam logic [7:0] CTRL_REG_ADDR = 8'h8f; // store_control_register
  localparam logic [7:0] RESET_SOURCE_REGISTER_REG_ADDR = 8'hef; // reset_source_register

  // field positions and reset values
  localparam int ONESHOT_BIT = 7; // read_oneshot_enable
  localparam int WEN_BIT = 0; // store_write_enable
  localparam int EEN_BIT = 1; // store_erase_enable
  localparam int FERR_BIT = 6; // flash_error_flag
  localparam logic [7:0] TIMING_RESET = 8'h80;
  localparam logic [7:0] TIMING_MASK = 8'h80; // only the one-shot bit is stored

  // unlock codes
  localparam logic [7:0] KEY_FIRST = 8'ha5;
  localparam logic [7:0] KEY_SECOND = 8'hf1;

  ////////////////////////////////////////////////////////////////////////////
  // flash geometry
  localparam int ADDR_W = 13; // 8192 bytes
  localparam int PAGE_W = 4; // 16 pages of 512 bytes
  localparam logic [15:0] USER_LIMIT = 16'h1dff; // last user byte
  localparam logic [12:0] LOCK_ADDR = 13'h1dff; // lock byte
  localparam logic [3:0] LOCK_PAGE = 4'he; // page holding the lock byte
  localparam logic [8:0] PAGE_OFF_LAST = 9'h1ff;
  localparam logic [8:0] PAGE_OFF_FIRST = 9'h000;
  localparam logic [7:0] ERASED = 8'hff;

  ////////////////////////////////////////////////////////////////////////////
  // timing: least times, rounded up to whole cycles
  localparam int CLK_MHZ = 50;
  localparam int WRITE_TIME_NS = 40000; // 40 us byte program
  localparam int ERASE_TIME_US = 10000; // 10 ms page erase
  localparam int CNT_W = 20;
  localparam int WRITE_CYCLES = (WRITE_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int ERASE_CYCLES = ERASE_TIME_US * CLK_MHZ;

  ////////////////////////////////////////////////////////////////////////////
  // unlock sequence states, gray along idle -> half -> open
  typedef enum logic [1:0] {
    LK_IDLE = 2'b00,
    LK_HALF = 2'b01,
    LK_OPEN = 2'b11,
    LK_DEAD = 2'b10
  } unlock_t;

  // operation engine states, gray in the listed order; merge -> hold, merge -> idle and hold -> idle flip two bits
  typedef enum logic [2:0] {
    E_BOOT = 3'b000,
    E_BOOTLD = 3'b001,
    E_IDLE = 3'b011,
    E_READ = 3'b010,
    E_MERGE = 3'b110,
    E_ERASE = 3'b111,
    E_HOLD = 3'b101
  } engine_t;

  ////////////////////////////////////////////////////////////////////////////
  // page number of a byte address
  function automatic logic [3:0] page_of(input logic [15:0] addr);
    page_of = addr[12:9];
  endfunction

  // page lock: first n pages locked, n = complement of lock byte
  function automatic logic page_locked(input logic [3:0] pg, input logic [7:0] lockb);
    page_locked = ({4'h0, pg} < ~lockb) || ((pg == LOCK_PAGE) && (lockb != ERASED));
  endfunction

endpackage

// file: logic/flash_byte_array.sv
/*
  byte-wide flash array model: one write port and one registered read port.
  assumes the owner sequences erases byte by byte and merges program data itself.
*/
`timescale 1ns/1ps
`default_nettype none

module flash_byte_array (
  // clock
  input wire logic clk_in,
  // access port
  input wire logic [12:0] addr_in,
  input wire logic we_in,
  input wire logic [7:0] wdata_in,
  output logic [7:0] rdata_out
);

  // storage, starts erased like blank flash
  logic [7:0] mem [0:8191] = '{default: 8'hff};
  logic [7:0] rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // write and registered read
  always_ff @(posedge clk_in) begin
    if (we_in) begin
      mem[addr_in] <= wdata_in;
    end
    rdata_q <= mem[addr_in];
  end

  assign rdata_out = rdata_q;

endmodule

`default_nettype wire

// file: verification/core_port_model.sv
/*
  model of the processor core and debug port issuing one-cycle requests to the guard.
  assumes commands arrive on go_in, changed at the falling clock edge.
*/
`timescale 1ns/1ps
`default_nettype none

module core_port_model (
  // clock and command
  input wire logic clk_in,
  input wire logic go_in,
  input wire logic [2:0] op_in,
  input wire logic [15:0] addr_in,
  input wire logic [7:0] data_in,
  input wire logic stall_in,
  // request pulses toward the guard
  output logic [6:0] req_out,
  output logic [15:0] addr_out,
  output logic [7:0] data_out
);
  ////////////////////////////////////////////////////////////////////////////
  // power-up state of the request lines
  initial begin
    req_out = 7'h00;
    addr_out = 16'h0000;
    data_out = 8'h00;
  end

  // one pulse a command; idle buses flip so stale values never look valid
  always @(negedge clk_in) begin
    if (go_in && !stall_in) begin
      req_out <= 7'h01 << op_in;
      addr_out <= addr_in;
      data_out <= data_in;
    end else begin
      req_out <= 7'h00;
      addr_out <= ~addr_out;
      data_out <= ~data_out;
    end
  end
endmodule

`default_nettype wire

// file: verification/flash_program_erase_guard_tb_top.sv
/*
  testbench for the program-flash guard: registers, unlock keys, program, erase,
  page locking and flash-error reset.
  assumes core_port_model stands in for the core and the debug port.
*/
`timescale 1ns/1ps
`default_nettype none

module flash_program_erase_guard_tb_top;
  import flash_guard_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // request kinds for the partner
  localparam logic [2:0] XW = 3'h0, CR = 3'h1, FE = 3'h2, DR = 3'h3;
  localparam logic [2:0] DW = 3'h4, DE = 3'h6;
  // bench-driven inputs
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [7:0] sa = 8'h00;
  logic sw = 1'b0;
  logic sr = 1'b0;
  logic [7:0] sd = 8'h00;
  logic go = 1'b0;
  logic [2:0] op = 3'h0;
  logic [15:0] ca = 16'h0000;
  logic [7:0] cd = 8'h00;
  logic orst = 1'b0;
  // partner and guard outputs
  logic [6:0] req;
  logic [15:0] pa;
  logic [7:0] pd, srd, crd, drd, r;
  logic crv, ramw, stall, ddone, dref, ferr, sone, sen;
  // bookkeeping
  int error_cnt = 0;
  int checks_done = 0;
  int evt = 0;
  int err_n = 0;
  int ref_n = 0;
  int ram_n = 0;
  int sen_n = 0;
  int run_len = 0;
  int stall_len = 0;
  logic stall_old = 1'b1;
  logic [7:0] last_rd = 8'h00;

  always #10 clk_in = ~clk_in;

  flash_program_erase_guard #(.ERASE_COUNT(20)) dut (
    .clk_in(clk_in), .rst_in(rst_in), .other_reset_in(orst),
    .sfr_addr_in(sa), .sfr_wr_in(sw), .sfr_rd_in(sr), .sfr_wdata_in(sd), .sfr_rdata_out(srd),
    .xwr_in(req[0]), .xaddr_in(pa), .xdata_in(pd), .cread_in(req[1]), .caddr_in(pa),
    .fetch_in(req[2]), .fetch_addr_in(pa), .cread_data_out(crd), .cread_valid_out(crv),
    .xram_wr_out(ramw), .stall_out(stall), .dbg_rd_in(req[3]), .dbg_wr_in(req[4]),
    .dbg_page_erase_in(req[5]), .dbg_device_erase_in(req[6]), .dbg_addr_in(pa),
    .dbg_wdata_in(pd), .dbg_rdata_out(drd), .dbg_done_out(ddone), .dbg_refused_out(dref),
    .flash_error_reset_out(ferr), .sense_oneshot_out(sone), .sense_enable_out(sen));

  core_port_model partner (.clk_in(clk_in), .go_in(go), .op_in(op), .addr_in(ca),
    .data_in(cd), .stall_in(stall), .req_out(req), .addr_out(pa), .data_out(pd));

  ////////////////////////////////////////////////////////////////////////////
  // answer monitor: pulses are sampled mid-cycle where they stand
  always @(negedge clk_in) begin
    if (crv === 1'b1) last_rd = crd;
    if (ddone === 1'b1) last_rd = drd;
    if (ferr === 1'b1) err_n++;
    if (dref === 1'b1) ref_n++;
    if (ramw === 1'b1) ram_n++;
    if (sen === 1'b1) sen_n++;
    if (stall === 1'b1) run_len++;
    if ((crv | ddone | ferr | dref | ramw | (stall_old & ~stall)) === 1'b1) evt++;
    if (stall_old === 1'b1 && stall === 1'b0) begin
      stall_len = run_len;
      run_len = 0;
    end
    stall_old = stall;
  end

  ////////////////////////////////////////////////////////////////////////////
  // shared tasks
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic do_reset;
    @(negedge clk_in);
    rst_in <= 1'b1;
    repeat (8) @(negedge clk_in);
    rst_in <= 1'b0;
    repeat (4) @(negedge clk_in);
  endtask

  // register access: strobe for one cycle, data valid the cycle after
  task automatic reg_io(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_in);
    sa <= a;
    sd <= d;
    sw <= wr;
    sr <= ~wr;
    @(negedge clk_in);
    sw <= 1'b0;
    sr <= 1'b0;
    @(negedge clk_in);
    r = srd;
  endtask

  task automatic keys(input logic [7:0] k1, input logic [7:0] k2);
    reg_io(1'b1, KEY_REG_ADDR, k1);
    reg_io(1'b1, KEY_REG_ADDR, k2);
    reg_io(1'b0, KEY_REG_ADDR, 8'h00);
  endtask

  // one partner request, then wait for its answer under a bound; quiet ones stay silent
  task automatic run(input logic [2:0] o, input logic [15:0] a, input logic [7:0] d,
                     input bit quiet = 1'b0);
    int e;
    int n;
    e = evt;
    n = 0;
    @(negedge clk_in);
    op <= o;
    ca <= a;
    cd <= d;
    go <= 1'b1;
    @(negedge clk_in);
    go <= 1'b0;
    while (!quiet && evt == e && n < 12000) begin
      @(negedge clk_in);
      n++;
    end
    repeat (3) @(negedge clk_in);
    if (quiet) chk("silent request", 8'(evt - e), 8'h00);
    else chk("answer in time", 8'(n < 12000), 8'h01);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_regs;
    reg_io(1'b0, TIMING_REG_ADDR, 8'h00);
    chk("timing reset", r, 8'h80);
    chk("oneshot level", {7'h00, sone}, 8'h01);
    reg_io(1'b1, TIMING_REG_ADDR, 8'h00);
    chk("oneshot cleared", {7'h00, sone}, 8'h00);
    reg_io(1'b0, 8'h10, 8'h00);
    chk("unmapped read", r, 8'h00);
    $display("test regs done");
  endtask

  task automatic t_program;
    reg_io(1'b1, CTRL_REG_ADDR, 8'h01);
    keys(KEY_FIRST, KEY_SECOND);
    chk("key open", r, 8'h03);
    run(XW, 16'h0100, 8'h5a);
    chk("program stall", 8'(stall_len >= 2000), 8'h01);
    reg_io(1'b0, KEY_REG_ADDR, 8'h00);
    chk("relocked", r, 8'h00);
    run(CR, 16'h0100, 8'h00);
    chk("programmed byte", last_rd, 8'h5a);
    keys(KEY_FIRST, KEY_SECOND);
    run(XW, 16'h0100, 8'hf0);
    run(CR, 16'h0100, 8'h00);
    chk("bits only clear", last_rd, 8'h50);
    $display("test program done");
  endtask

  task automatic t_nokey;
    run(XW, 16'h0100, 8'h00, 1'b1);
    reg_io(1'b0, KEY_REG_ADDR, 8'h00);
    chk("write before keys", r, 8'h02);
    keys(KEY_FIRST, KEY_SECOND);
    chk("still blocked", r, 8'h02);
    run(CR, 16'h0100, 8'h00);
    chk("byte untouched", last_rd, 8'h50);
    do_reset();
    keys(KEY_SECOND, KEY_FIRST);
    chk("wrong order", r, 8'h02);
    do_reset();
    $display("test no-key done");
  endtask

  task automatic t_erase_ram;
    int m;
    reg_io(1'b1, CTRL_REG_ADDR, 8'h03);
    keys(KEY_FIRST, KEY_SECOND);
    run(XW, 16'h0105, 8'h00);
    chk("erase stall", 8'(stall_len >= 532), 8'h01);
    m = sen_n;
    run(CR, 16'h0100, 8'h00);
    chk("page erased", last_rd, ERASED);
    chk("one sense pulse", 8'(sen_n - m), 8'h01);
    run(CR, 16'h01ff, 8'h00);
    chk("page end erased", last_rd, ERASED);
    reg_io(1'b1, CTRL_REG_ADDR, 8'h00);
    m = ram_n;
    run(XW, 16'h0100, 8'h00);
    chk("write to ram", 8'(ram_n - m), 8'h01);
    run(CR, 16'h0100, 8'h00);
    chk("flash kept", last_rd, ERASED);
    $display("test erase and ram done");
  endtask

  task automatic t_error;
    int e;
    e = err_n;
    run(FE, 16'h1e00, 8'h00);
    chk("fetch above limit", 8'(err_n - e), 8'h01);
    reg_io(1'b0, RESET_SOURCE_REGISTER_REG_ADDR, 8'h00);
    chk("error flag", r, 8'h40);
    run(CR, 16'h1e00, 8'h00);
    chk("reserved read", 8'(err_n - e), 8'h02);
    reg_io(1'b1, CTRL_REG_ADDR, 8'h03);
    run(XW, 16'h1c00, 8'h00);
    chk("lock page erase", 8'(err_n - e), 8'h03);
    orst <= 1'b1;
    reg_io(1'b0, RESET_SOURCE_REGISTER_REG_ADDR, 8'h00);
    orst <= 1'b0;
    chk("flag cleared", r, 8'h00);
    $display("test error done");
  endtask

  task automatic t_lock;
    int e;
    int f;
    run(DW, 16'h1dff, 8'hfe);
    f = ref_n;
    run(DR, 16'h0000, 8'h00);
    chk("debug refused", 8'(ref_n - f), 8'h01);
    run(DR, 16'h1dff, 8'h00);
    chk("lock byte read", last_rd, 8'hfe);
    e = err_n;
    run(FE, 16'h0200, 8'h00, 1'b1);
    run(CR, 16'h0000, 8'h00);
    chk("unlocked fw", 8'(err_n - e), 8'h01);
    reg_io(1'b1, CTRL_REG_ADDR, 8'h01);
    run(XW, 16'h1dff, 8'h00);
    chk("lock byte write", 8'(err_n - e), 8'h02);
    run(FE, 16'h0000, 8'h00, 1'b1);
    run(CR, 16'h0000, 8'h00);
    chk("locked fw read", last_rd, ERASED);
    chk("no error", 8'(err_n - e), 8'h02);
    run(DE, 16'h0000, 8'h00);
    run(DR, 16'h1dff, 8'h00);
    chk("lock byte erased", last_rd, ERASED);
    run(DR, 16'h0000, 8'h00);
    chk("page open again", 8'(ref_n - f), 8'h01);
    $display("test lock done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence and watchdog
  initial begin
    do_reset();
    t_regs();
    t_program();
    t_nokey();
    t_erase_ram();
    t_error();
    t_lock();
    tally_and_finish();
  end

  initial begin
    repeat (60000) @(posedge clk_in);
    error_cnt++;
    tally_and_finish();
  end
endmodule

`default_nettype wire
